//--- inc/ssc_pkg.sv
package ssc_pkg;

	// Power and management states, Gray coded along run -> grant -> sleep.
	typedef enum logic [2:0] {
		SSC_RUN   = 3'b000,
		SSC_GRANT = 3'b001,
		SSC_SLEEP = 3'b011,
		SSC_SAVE  = 3'b010,
		SSC_ACK   = 3'b110,
		SSC_SMM   = 3'b111,
		SSC_TRIST = 3'b101
	} ssc_state_e;

	// Bus special-transaction requests issued by the block.
	typedef struct packed {
		logic grant_ack;
		logic smi_ack;
	} ssc_bus_req_s;

	// Clock gate enables, one per unit group.
	typedef struct packed {
		logic core_en;
		logic bus_en;
		logic apic_en;
	} ssc_clk_en_s;

	localparam int         SSC_SYNC_DEPTH = 3;
	localparam logic [3:0] SSC_SAVE_CYCLES = 4'h4;
	localparam logic [3:0] SSC_CNT_ZERO    = 4'h0;
	localparam logic [3:0] SSC_CNT_ONE     = 4'h1;

endpackage

//--- src/ssc_sleep_smi_ctrl.sv
`timescale 1ns/1ns

// Overview of operation
// - Halt-clocks request enters Stop-Grant, sends acknowledge, stops core clocks only.
// - Sleep request taken only in Stop-Grant; chipset must only assert it there.
// - Sleep gates every unit clock including bus; only the PLL keeps running.
// - Asleep, no snoops answered and no interrupts accepted.
// - Asleep, only reset assertion or sleep release are acted upon.
// - Sleep release returns to Stop-Grant and restarts bus and apic clocks; core clocks stay stopped.
// - Management interrupt input is synchronised before use.
// - Accepted management interrupt saves state and enters management mode.
// - Management mode issues acknowledge transaction, then starts handler.
module ssc_sleep_smi_ctrl
	import ssc_pkg::*;
#(
	parameter logic [3:0] SAVE_CYCLES = SSC_SAVE_CYCLES
) (
	// Clock and reset.
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	// Sideband pins from chipset, asynchronous.
	input  wire logic         halt_clocks_request_n,
	input  wire logic         sleep_request_n,
	input  wire logic         sys_mgmt_irq_n,
	// Core requests and handshakes.
	input  wire logic         snoop_req,
	input  wire logic         intr_req,
	input  wire logic         bus_req_ready,
	input  wire logic         handler_done,
	// Bus transaction requests.
	output ssc_bus_req_s      bus_req,
	// Clock gates and status.
	output ssc_clk_en_s       clk_en,
	output logic              snoop_accept,
	output logic              intr_accept,
	output logic              state_save,
	output logic              handler_start,
	output logic              sys_mgmt_mode,
	output logic              outputs_tristate
);

	logic [SSC_SYNC_DEPTH-1:0] halt_sync_q;
	logic [SSC_SYNC_DEPTH-1:0] sleep_sync_q;
	logic [SSC_SYNC_DEPTH-1:0] smi_sync_q;
	logic                      halt_q;
	logic                      sleep_q;
	logic                      smi_q;
	logic                      smi_prev_q;
	logic                      rst_prev_q;
	logic                      tristate_q;
	logic [3:0]                save_cnt_q;
	logic                      grant_ack_q;
	logic                      grant_sent_q;
	logic                      smi_ack_q;
	ssc_state_e                state_q;
	ssc_state_e                state_d;
	logic                      smi_edge;

	// Sync three stages, free-running through reset so that a level held
	// across reset release is already filtered at the first active edge.
	// halt, sleep and smi synchronisers.
	always_ff @(posedge sys_clk) begin
		halt_sync_q  <= {halt_sync_q[SSC_SYNC_DEPTH-2:0], ~halt_clocks_request_n};
		sleep_sync_q <= {sleep_sync_q[SSC_SYNC_DEPTH-2:0], ~sleep_request_n};
		smi_sync_q   <= {smi_sync_q[SSC_SYNC_DEPTH-2:0], ~sys_mgmt_irq_n};
	end

	// A level counts only once the second and third stages agree.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			halt_q  <= 1'b0;
			sleep_q <= 1'b0;
			smi_q   <= 1'b0;
		end else begin
			if (halt_sync_q[SSC_SYNC_DEPTH-2] == halt_sync_q[SSC_SYNC_DEPTH-1])
				halt_q <= halt_sync_q[SSC_SYNC_DEPTH-1];
			if (sleep_sync_q[SSC_SYNC_DEPTH-2] == sleep_sync_q[SSC_SYNC_DEPTH-1])
				sleep_q <= sleep_sync_q[SSC_SYNC_DEPTH-1];
			if (smi_sync_q[SSC_SYNC_DEPTH-2] == smi_sync_q[SSC_SYNC_DEPTH-1])
				smi_q <= smi_sync_q[SSC_SYNC_DEPTH-1];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			smi_prev_q <= 1'b0;
		else
			smi_prev_q <= smi_q;
	end

	assign smi_edge = smi_q & ~smi_prev_q;

	// The strap reads the second and third sync stages, so the pin must be low for two edges before
	// release; a shorter glitch around release is ignored.
	// strap at reset release.
	always_ff @(posedge sys_clk) begin
		rst_prev_q <= rstn;
		if (!rstn)
			tristate_q <= 1'b0;
		else if (!rst_prev_q && smi_sync_q[SSC_SYNC_DEPTH-2]
			&& smi_sync_q[SSC_SYNC_DEPTH-1])
			tristate_q <= 1'b1;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			SSC_RUN: begin
				if (tristate_q)
					state_d = SSC_TRIST;
				else if (smi_edge)
					state_d = SSC_SAVE;
				else if (halt_q)
					state_d = SSC_GRANT;
			end
			SSC_GRANT: begin
				if (sleep_q)
					state_d = SSC_SLEEP;
				else if (!halt_q)
					state_d = SSC_RUN;
			end
			SSC_SLEEP: begin
				if (!sleep_q)
					state_d = SSC_GRANT;
			end
			SSC_SAVE: begin
				if (save_cnt_q == SSC_CNT_ONE)
					state_d = SSC_ACK;
			end
			SSC_ACK: begin
				if (bus_req_ready)
					state_d = SSC_SMM;
			end
			SSC_SMM: begin
				if (handler_done)
					state_d = SSC_RUN;
			end
			SSC_TRIST: state_d = SSC_TRIST;
			default:   state_d = SSC_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			state_q <= SSC_RUN;
		else
			state_q <= state_d;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			save_cnt_q <= SSC_CNT_ZERO;
		else if (state_q == SSC_RUN && state_d == SSC_SAVE)
			save_cnt_q <= SAVE_CYCLES;
		else if (save_cnt_q != SSC_CNT_ZERO)
			save_cnt_q <= save_cnt_q - SSC_CNT_ONE;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			grant_ack_q  <= 1'b0;
			grant_sent_q <= 1'b0;
		end else begin
			if (state_q != SSC_GRANT && state_q != SSC_SLEEP)
				grant_sent_q <= 1'b0;
			else if (grant_ack_q && bus_req_ready)
				grant_sent_q <= 1'b1;
			grant_ack_q <= (state_q == SSC_GRANT) && !grant_sent_q
				&& !(grant_ack_q && bus_req_ready);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			smi_ack_q <= 1'b0;
		else
			smi_ack_q <= (state_d == SSC_ACK);
	end

	assign bus_req.grant_ack = grant_ack_q;
	assign bus_req.smi_ack   = smi_ack_q;

	assign clk_en.core_en = !(state_q == SSC_GRANT || state_q == SSC_SLEEP
		|| state_q == SSC_TRIST);
	assign clk_en.bus_en  = !(state_q == SSC_SLEEP || state_q == SSC_TRIST);
	assign clk_en.apic_en = !(state_q == SSC_SLEEP || state_q == SSC_TRIST);

	assign snoop_accept = snoop_req && state_q != SSC_SLEEP && state_q != SSC_TRIST;
	assign intr_accept  = intr_req && state_q != SSC_SLEEP && state_q != SSC_TRIST
		&& state_q != SSC_SAVE && state_q != SSC_ACK && state_q != SSC_SMM;

	assign state_save       = (state_q == SSC_SAVE);
	assign sys_mgmt_mode    = (state_q == SSC_ACK || state_q == SSC_SMM);
	assign handler_start    = (state_q == SSC_ACK) && bus_req_ready;
	assign outputs_tristate = (state_q == SSC_TRIST);

	AST_SLEEP_CLOCKS: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == SSC_SLEEP |-> !clk_en.bus_en && !clk_en.core_en && !clk_en.apic_en)
		else $error("clocks running in sleep");

	AST_SLEEP_ENTRY: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q != SSC_SLEEP ##1 state_q == SSC_SLEEP |-> $past(state_q) == SSC_GRANT)
		else $error("sleep entered outside grant");

	AST_SLEEP_DEAF: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == SSC_SLEEP |-> !snoop_accept && !intr_accept)
		else $error("request accepted in sleep");

	AST_SLEEP_STAY: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == SSC_SLEEP && sleep_q |=> state_q == SSC_SLEEP)
		else $error("sleep left without release");

	AST_SLEEP_EXIT: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == SSC_SLEEP && !sleep_q |=> state_q == SSC_GRANT && clk_en.bus_en)
		else $error("sleep release not honoured");

	AST_GRANT_ACK: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == SSC_RUN ##1 state_q == SSC_GRANT |=> grant_ack_q)
		else $error("no grant acknowledge");

	AST_GRANT_CORE: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == SSC_GRANT |-> !clk_en.core_en && clk_en.bus_en && clk_en.apic_en)
		else $error("wrong gating in grant");

	sequence s_smi_seen;
		state_q == SSC_RUN && !tristate_q && smi_edge;
	endsequence

	AST_SMI_SAVE: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_smi_seen |=> state_save [*4] ##1 sys_mgmt_mode)
		else $error("save or mode entry wrong");

	AST_SMI_ACK: assert property (@(posedge sys_clk) disable iff (!rstn)
		handler_start |-> bus_req.smi_ack && sys_mgmt_mode)
		else $error("handler before acknowledge");

	AST_SMI_SYNC: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(smi_q) |-> $past(smi_sync_q[2]) && $past(smi_sync_q[1]))
		else $error("unsynchronised smi");

	AST_TRISTATE: assert property (@(posedge sys_clk) disable iff (!rstn)
		tristate_q && state_q == SSC_RUN |=> outputs_tristate)
		else $error("no tristate after strap");

endmodule

//--- verification/ssc_chipset_model.sv
`timescale 1ns/1ns

module ssc_chipset_model (
	// Clock and wishes from the bench.
	input  wire logic sys_clk,
	input  wire logic want_halt,
	input  wire logic want_sleep,
	input  wire logic want_smi,
	// Bus handshake watched to know Stop-Grant.
	input  wire logic grant_ack,
	input  wire logic bus_req_ready,
	// Sideband pins, low active.
	output logic      halt_clocks_request_n,
	output logic      sleep_request_n,
	output logic      sys_mgmt_irq_n
);

	logic grant_seen_q = 1'b0;

	initial begin
		halt_clocks_request_n = 1'b1;
		sleep_request_n       = 1'b1;
		sys_mgmt_irq_n        = 1'b1;
	end

	// Stop-Grant known once its acknowledge is taken.
	always @(posedge sys_clk) begin
		if (halt_clocks_request_n)
			grant_seen_q <= 1'b0;
		else if (grant_ack && bus_req_ready)
			grant_seen_q <= 1'b1;
	end

	// Pins move off the edge, since the chipset is not tied to our clock phase.
	always @(posedge sys_clk) begin
		#3;
		halt_clocks_request_n <= !want_halt;
		sleep_request_n       <= !(want_sleep && grant_seen_q);
		sys_mgmt_irq_n        <= !want_smi;
	end

endmodule

//--- verification/testbench.sv
`timescale 1ns/1ns

module testbench;
	import ssc_pkg::*;

	localparam logic [3:0] N_SAVE = 4'h4;

	logic         sys_clk       = 1'b0;
	logic         rstn          = 1'b0;
	logic         want_halt     = 1'b0;
	logic         want_sleep    = 1'b0;
	logic         want_smi      = 1'b0;
	logic         bus_req_ready = 1'b0;
	logic         handler_done  = 1'b0;
	logic         halt_n;
	logic         sleep_n;
	logic         smi_n;
	ssc_bus_req_s bus_req;
	ssc_clk_en_s  clk_en;
	logic         snoop_accept;
	logic         intr_accept;
	logic         state_save;
	logic         handler_start;
	logic         sys_mgmt_mode;
	logic         outputs_tristate;
	int           fail_count    = 0;
	int           n_tests       = 0;
	int           k;
	// Row: halt, sleep, smi, then grant ack, core, bus, apic, snoop, intr, mode.
	logic [9:0]   rows [6]      = '{10'h03e, 10'h25e, 10'h300, 10'h380, 10'h21e, 10'h03e};

	always #10 sys_clk = ~sys_clk;

	ssc_chipset_model chipset (
		.sys_clk               (sys_clk),
		.want_halt             (want_halt),
		.want_sleep            (want_sleep),
		.want_smi              (want_smi),
		.grant_ack             (bus_req.grant_ack),
		.bus_req_ready         (bus_req_ready),
		.halt_clocks_request_n (halt_n),
		.sleep_request_n       (sleep_n),
		.sys_mgmt_irq_n        (smi_n)
	);

	ssc_sleep_smi_ctrl #(.SAVE_CYCLES(N_SAVE)) uut (
		.sys_clk               (sys_clk),
		.rstn                  (rstn),
		.halt_clocks_request_n (halt_n),
		.sleep_request_n       (sleep_n),
		.sys_mgmt_irq_n        (smi_n),
		.snoop_req             (1'b1),
		.intr_req              (1'b1),
		.bus_req_ready         (bus_req_ready),
		.handler_done          (handler_done),
		.bus_req               (bus_req),
		.clk_en                (clk_en),
		.snoop_accept          (snoop_accept),
		.intr_accept           (intr_accept),
		.state_save            (state_save),
		.handler_start         (handler_start),
		.sys_mgmt_mode         (sys_mgmt_mode),
		.outputs_tristate      (outputs_tristate)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		#2 chk({3'h0, outputs_tristate, clk_en, sys_mgmt_mode}, 8'h0e);
		rstn = 1'b1;
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			{want_halt, want_sleep, want_smi} = rows[i][9:7];
			repeat (10) @(posedge sys_clk);
			#2 chk({outputs_tristate, bus_req.grant_ack, clk_en, snoop_accept, intr_accept,
				sys_mgmt_mode}, {1'b0, rows[i][6:0]});
			bus_req_ready = 1'b1;
			@(posedge sys_clk);
			#2 bus_req_ready = 1'b0;
		end
		$display("state row test done");
		want_smi = 1'b1;
		repeat (3) @(posedge sys_clk);
		#2 chk({7'h0, state_save}, 8'h00);
		for (k = 0; k < 20 && state_save !== 1'b1; k++) begin
			@(posedge sys_clk);
			#2;
		end
		chk({7'h0, state_save}, 8'h01);
		for (k = 0; k < 20 && state_save === 1'b1; k++) begin
			@(posedge sys_clk);
			#2;
		end
		chk(8'(k), {4'h0, N_SAVE});
		chk({5'h0, sys_mgmt_mode, bus_req.smi_ack, intr_accept}, 8'h06);
		bus_req_ready = 1'b1;
		want_smi = 1'b0;
		#1 chk({7'h0, handler_start}, 8'h01);
		@(posedge sys_clk);
		#2 bus_req_ready = 1'b0;
		chk({6'h0, sys_mgmt_mode, bus_req.smi_ack}, 8'h02);
		handler_done = 1'b1;
		@(posedge sys_clk);
		#2 handler_done = 1'b0;
		repeat (2) @(posedge sys_clk);
		#2 chk({7'h0, sys_mgmt_mode}, 8'h00);
		$display("management test done");
		// The pin must already be low when reset lets go, as a strap would be.
		want_smi = 1'b1;
		rstn = 1'b0;
		repeat (4) @(posedge sys_clk);
		#2 rstn = 1'b1;
		repeat (3) @(posedge sys_clk);
		#2 chk({7'h0, outputs_tristate}, 8'h01);
		$display("strap test done");
		end_of_test();
	end

endmodule
